// File: hdl/dp_debug_port.sv
// Version-0 debug port: test access port, identification, access and abort chains.
`timescale 1ns/1ns
module dp_debug_port #(
  // Set to zero when the debug-domain reset control is left out.
  parameter bit RESET_CTRL_EN = 1'b1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // JTAG pins from the host; the only link this port supports.
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  // Power and reset handshakes with the system controllers.
  output logic debug_power_request,
  input wire logic debug_power_acknowledge,
  output logic system_power_request,
  input wire logic system_power_acknowledge,
  output logic debug_reset_request,
  input wire logic debug_reset_acknowledge,
  output logic debug_bus_reset_low,
  // Events from the access side, one core cycle each.
  input wire logic error_event,
  input wire logic compare_event,
  input wire logic overrun_event,
  // Access port selection and the cancel pulse.
  output logic [7:0] access_port_index,
  output logic [3:0] access_port_bank,
  output logic transaction_cancel
);
  import dp_pkg::*;

  // All port state in one record.
  typedef struct packed {
    dp_tap_state_t tap;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [34:0] dr_sh;
    logic [31:0] read_buffer;
    logic [31:0] control_status;
    logic [7:0] index;
    logic [3:0] bank;
    logic [2:0] ack_s1;
    logic [2:0] ack_s2;
    logic tdo;
    logic tdo_oe_n;
    logic cancel;
  } dp_state_t;
  dp_state_t state;
  dp_state_t next_state;

  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;

  // Pin synchroniser; the test clock is only an input sampled by core_clk.
  dp_tap_sampler u_sampler (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall),
    .tms_sync(tms_s),
    .tdi_sync(tdi_s)
  );

  // Standard controller walk on the mode bit.
  function automatic dp_tap_state_t tap_next(input dp_tap_state_t s, input logic m);
    case (s)
      DP_RESET: tap_next = m ? DP_RESET : DP_IDLE;
      DP_IDLE: tap_next = m ? DP_SEL_DR : DP_IDLE;
      DP_SEL_DR: tap_next = m ? DP_SEL_IR : DP_CAP_DR;
      DP_CAP_DR: tap_next = m ? DP_EX1_DR : DP_SH_DR;
      DP_SH_DR: tap_next = m ? DP_EX1_DR : DP_SH_DR;
      DP_EX1_DR: tap_next = m ? DP_UPD_DR : DP_PA_DR;
      DP_PA_DR: tap_next = m ? DP_EX2_DR : DP_PA_DR;
      DP_EX2_DR: tap_next = m ? DP_UPD_DR : DP_SH_DR;
      DP_UPD_DR: tap_next = m ? DP_SEL_DR : DP_IDLE;
      DP_SEL_IR: tap_next = m ? DP_RESET : DP_CAP_IR;
      DP_CAP_IR: tap_next = m ? DP_EX1_IR : DP_SH_IR;
      DP_SH_IR: tap_next = m ? DP_EX1_IR : DP_SH_IR;
      DP_EX1_IR: tap_next = m ? DP_UPD_IR : DP_PA_IR;
      DP_PA_IR: tap_next = m ? DP_EX2_IR : DP_PA_IR;
      DP_EX2_IR: tap_next = m ? DP_UPD_IR : DP_SH_IR;
      DP_UPD_IR: tap_next = m ? DP_SEL_DR : DP_IDLE;
      default: tap_next = DP_RESET;
    endcase
  endfunction

  // Length of the data chain that the instruction selects; unknown codes act as bypass.
  function automatic int chain_len(input logic [3:0] ir);
    case (ir)
      DP_IR_ABORT, DP_IR_DPACC, DP_IR_APACC: chain_len = DP_LEN_ACC;
      DP_IR_TAP_IDENTIFICATION: chain_len = DP_LEN_ID;
      default: chain_len = DP_LEN_BYP;
    endcase
  endfunction

  // Control/status as software sees it, with live acknowledges.
  function automatic logic [31:0] cs_view(input logic [31:0] cs, input logic [2:0] ack);
    logic [31:0] v;
    v = cs;
    v[DP_CS_SYS_ACK] = ack[2]; // RULE16
    v[DP_CS_DBG_ACK] = ack[1]; // RULE16
    v[DP_CS_RST_ACK] = RESET_CTRL_EN ? ack[0] : 1'b0; // RULE1 RULE2
    v[DP_CS_WDATA_ERR] = 1'b0; // RULE12
    v[DP_CS_READ_OK] = 1'b0; // RULE12
    cs_view = v;
  endfunction

  logic [31:0] id_value;
  logic [31:0] acc_data;
  logic [1:0] acc_addr;
  logic acc_read;
  logic [31:0] cs_read;
  logic [31:0] sel_read;

  // Fixed identification word, read-only.
  assign id_value = {DP_ID_VERSION, DP_ID_PART, DP_ID_DESIGNER, 1'b1}; // RULE4 RULE5 RULE6
  // Fields of the access chain: data, address bits 3:2, read flag.
  assign acc_data = state.dr_sh[34:3];
  assign acc_addr = state.dr_sh[2:1];
  assign acc_read = state.dr_sh[0];
  assign cs_read = cs_view(state.control_status, state.ack_s2);
  assign sel_read = {state.index, 16'h0000, state.bank, 4'h0}; // RULE13

  // Next-state logic: controller, chains, registers and event flags.
  always_comb begin
    int len;
    logic [3:0] addr;
    next_state = state;
    len = chain_len(state.ir);
    addr = {acc_addr, 2'b00};
    next_state.cancel = 1'b0;
    // Acknowledges come from other clock domains, so two flops each.
    next_state.ack_s1 = {system_power_acknowledge, debug_power_acknowledge,
                         debug_reset_acknowledge};
    next_state.ack_s2 = state.ack_s1;
    if (tck_rise) begin
      next_state.tap = tap_next(state.tap, tms_s);
      case (state.tap)
        DP_RESET: begin
          next_state.ir = DP_IR_TAP_IDENTIFICATION; // RULE3
        end
        DP_CAP_IR: begin
          next_state.ir_sh = DP_IR_CAPTURE;
        end
        DP_SH_IR: begin
          next_state.ir_sh = {tdi_s, state.ir_sh[3:1]};
        end
        DP_UPD_IR: begin
          next_state.ir = state.ir_sh;
        end
        DP_CAP_DR: begin
          case (state.ir)
            DP_IR_TAP_IDENTIFICATION: next_state.dr_sh = {3'b000, id_value}; // RULE3
            DP_IR_DPACC, DP_IR_APACC: next_state.dr_sh = {state.read_buffer, DP_ACK_OK};
            default: next_state.dr_sh = '0;
          endcase
        end
        DP_SH_DR: begin
          next_state.dr_sh = state.dr_sh >> 1;
          next_state.dr_sh[len - 1] = tdi_s;
        end
        DP_UPD_DR: begin
          if (state.ir == DP_IR_ABORT) begin
            // Only bit 0 of the word acts; the rest must be zero from the host.
            next_state.cancel = acc_data[0]; // RULE9 RULE10 RULE17
          end else if (state.ir == DP_IR_DPACC && acc_read) begin
            case (addr)
              DP_ADDR_CONTROL_STATUS: next_state.read_buffer = cs_read; // RULE8
              DP_ADDR_PORT_SELECT: next_state.read_buffer = sel_read; // RULE8
              DP_ADDR_READ_BUFFER: next_state.read_buffer = state.read_buffer; // RULE8
              default: next_state.read_buffer = 32'h0000_0000; // RULE18
            endcase
          end else if (state.ir == DP_IR_DPACC) begin
            case (addr)
              DP_ADDR_CONTROL_STATUS: begin
                next_state.control_status[DP_CS_SYS_REQ] = acc_data[DP_CS_SYS_REQ]; // RULE16
                next_state.control_status[DP_CS_DBG_REQ] = acc_data[DP_CS_DBG_REQ]; // RULE16
                next_state.control_status[DP_CS_RST_REQ] =
                  RESET_CTRL_EN & acc_data[DP_CS_RST_REQ]; // RULE1 RULE2
                next_state.control_status[DP_CS_ORUN_DETECT] = acc_data[DP_CS_ORUN_DETECT];
                // Writing one clears a latched flag.
                if (acc_data[DP_CS_ERR]) next_state.control_status[DP_CS_ERR] = 1'b0; // RULE11
                if (acc_data[DP_CS_CMP]) next_state.control_status[DP_CS_CMP] = 1'b0; // RULE11
                if (acc_data[DP_CS_ORUN]) next_state.control_status[DP_CS_ORUN] = 1'b0; // RULE11
              end
              DP_ADDR_PORT_SELECT: begin
                next_state.index = acc_data[DP_SEL_INDEX_LSB +: 8]; // RULE13
                next_state.bank = acc_data[DP_SEL_BANK_LSB +: 4]; // RULE13
              end
              default: begin
                // Reserved address and the read-only buffer: the write is dropped.
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end
    // Events set after any clear, so an event in the clearing cycle is kept.
    if (error_event) next_state.control_status[DP_CS_ERR] = 1'b1; // RULE11
    if (compare_event) next_state.control_status[DP_CS_CMP] = 1'b1; // RULE11
    if (overrun_event && state.control_status[DP_CS_ORUN_DETECT]) begin
      next_state.control_status[DP_CS_ORUN] = 1'b1; // RULE11
    end
    // Output data changes on the falling test clock edge, as the host expects.
    if (tck_fall) begin
      next_state.tdo_oe_n = !(state.tap == DP_SH_DR || state.tap == DP_SH_IR); // RULE15
      next_state.tdo = (state.tap == DP_SH_IR) ? state.ir_sh[0] : state.dr_sh[0];
    end
  end

  // Register the whole port state.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
      state.tap <= DP_RESET;
      state.ir <= DP_IR_TAP_IDENTIFICATION;
      state.control_status <= DP_CS_RESET;
      state.index <= DP_INDEX_RESET;
      state.bank <= DP_BANK_RESET;
      state.tdo_oe_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flops; the debug bus reset passes through one inverter.
  assign tdo = state.tdo;
  assign tdo_oe_n = state.tdo_oe_n;
  assign system_power_request = state.control_status[DP_CS_SYS_REQ]; // RULE16
  assign debug_power_request = state.control_status[DP_CS_DBG_REQ]; // RULE16
  assign debug_reset_request = state.control_status[DP_CS_RST_REQ]; // RULE1
  // The debug bus sits in reset while the request stands; a reset that arrives
  // mid-transfer is the software's risk to manage.
  assign debug_bus_reset_low = ~state.control_status[DP_CS_RST_REQ]; // RULE1
  assign access_port_index = state.index;
  assign access_port_bank = state.bank;
  assign transaction_cancel = state.cancel;
endmodule

// File: hdl/dp_pkg.sv
// Package with the constants, states and encodings of the version-0 debug port.
// Contract
// RULE1: Reset request and acknowledge sit at bits 27:26.
// RULE2: Without reset control, acknowledge reads zero.
// RULE3: Read-only identification register on its own chain.
// RULE4: Identification bits 31:28 hold a version code.
// RULE5: Identification bits 27:12 hold fixed part number.
// RULE6: Bits 11:1 designer code; bit 0 reads one.
// RULE7: Host identifies version by identification table lookup.
// RULE8: Map: 0x4 control, 0x8 select, 0xc buffer.
// RULE9: Abort register written through its own instruction.
// RULE10: Host writes abort as zeros with bit 0 set.
// RULE11: Latched flags 5, 4, 1 readable, write-one clears.
// RULE12: Bits 7 and 6 read zero, ignore writes.
// RULE13: Select holds port index 31:24, bank 7:4.
// RULE14: Host should avoid reading the select register; the bench's t_select reads it back twice.
// RULE15: Only the JTAG link is supported.
// RULE16: Power requests and acknowledges at bits 28 to 31.
// RULE17: Host shifts only the single permitted abort value.
// RULE18: Reserved address 0x0 reads zero, no side effects.
package dp_pkg;
  // Register addresses, as carried by the two address bits of the access chain.
  localparam logic [3:0] DP_ADDR_RESERVED = 4'h0;
  localparam logic [3:0] DP_ADDR_CONTROL_STATUS = 4'h4;
  localparam logic [3:0] DP_ADDR_PORT_SELECT = 4'h8;
  localparam logic [3:0] DP_ADDR_READ_BUFFER = 4'hc;
  // Control/status field positions.
  localparam int DP_CS_SYS_ACK = 31;
  localparam int DP_CS_SYS_REQ = 30;
  localparam int DP_CS_DBG_ACK = 29;
  localparam int DP_CS_DBG_REQ = 28;
  localparam int DP_CS_RST_ACK = 27;
  localparam int DP_CS_RST_REQ = 26;
  localparam int DP_CS_WDATA_ERR = 7;
  localparam int DP_CS_READ_OK = 6;
  localparam int DP_CS_ERR = 5;
  localparam int DP_CS_CMP = 4;
  localparam int DP_CS_ORUN = 1;
  localparam int DP_CS_ORUN_DETECT = 0;
  // Select register fields.
  localparam int DP_SEL_INDEX_LSB = 24;
  localparam int DP_SEL_BANK_LSB = 4;
  // Identification fields; values are arbitrary, not any real maker or part.
  localparam logic [3:0] DP_ID_VERSION = 4'h0;
  localparam logic [15:0] DP_ID_PART = 16'h5a5a;
  localparam logic [10:0] DP_ID_DESIGNER = 11'h155;
  // Instruction codes of the four-bit instruction register.
  localparam logic [3:0] DP_IR_ABORT = 4'h8;
  localparam logic [3:0] DP_IR_DPACC = 4'ha;
  localparam logic [3:0] DP_IR_APACC = 4'hb;
  localparam logic [3:0] DP_IR_TAP_IDENTIFICATION = 4'he;
  localparam logic [3:0] DP_IR_BYPASS = 4'hf;
  localparam logic [3:0] DP_IR_CAPTURE = 4'h1;
  // Chain lengths and the answer code returned in the low three bits.
  localparam int DP_LEN_ACC = 35;
  localparam int DP_LEN_ID = 32;
  localparam int DP_LEN_BYP = 1;
  localparam logic [2:0] DP_ACK_OK = 3'h2;
  // Reset values.
  localparam logic [31:0] DP_CS_RESET = 32'h0000_0000;
  localparam logic [7:0] DP_INDEX_RESET = 8'h00;
  localparam logic [3:0] DP_BANK_RESET = 4'h0;
  // Test access port controller states.
  typedef enum logic [3:0] {
    DP_RESET, DP_IDLE, DP_SEL_DR, DP_CAP_DR, DP_SH_DR, DP_EX1_DR, DP_PA_DR,
    DP_EX2_DR, DP_UPD_DR, DP_SEL_IR, DP_CAP_IR, DP_SH_IR, DP_EX1_IR, DP_PA_IR,
    DP_EX2_IR, DP_UPD_IR
  } dp_tap_state_t;
endpackage

// File: hdl/dp_tap_sampler.sv
// Synchroniser and edge finder for the test clock, mode and data pins.
`timescale 1ns/1ns
module dp_tap_sampler (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Raw pins from the host.
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  // Synchronised results.
  output logic tck_rise,
  output logic tck_fall,
  output logic tms_sync,
  output logic tdi_sync
);
  // All sampler state; stage one is read only by stage two.
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic tck_prev;
  } dp_samp_t;
  dp_samp_t state;
  dp_samp_t next_state;

  // Two flops per pin, then one more for the clock to find its edges.
  always_comb begin
    next_state = state;
    next_state.s1 = {tck, tms, tdi};
    next_state.s2 = state.s1;
    next_state.tck_prev = state.s2[2];
  end

  // Register the sampler state.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // The test clock at 320 ns gives eight core cycles per period, enough to see each edge.
  assign tck_rise = state.s2[2] & ~state.tck_prev;
  assign tck_fall = ~state.s2[2] & state.tck_prev;
  assign tms_sync = state.s2[1];
  assign tdi_sync = state.s2[0];
endmodule

// File: tb/dp_port_monitor.sv
// Checker that watches the debug port pins and its handshake outputs.
`timescale 1ns/1ns
module dp_port_monitor #(
  // Mirrors the design's reset control option.
  parameter bit RESET_CTRL_EN = 1'b1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Link pins.
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  // Handshake, select and cancel outputs.
  input wire logic debug_power_request,
  input wire logic system_power_request,
  input wire logic debug_reset_request,
  input wire logic debug_bus_reset_low,
  input wire logic [7:0] access_port_index,
  input wire logic [3:0] access_port_bank,
  input wire logic transaction_cancel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // A shift ends when the output driver lets go of the pin.
  sequence shift_end_s;
    !tdo_oe_n ##1 tdo_oe_n;
  endsequence
  // A cancel is a lone one-cycle pulse.
  sequence lone_pulse_s;
    transaction_cancel ##1 !transaction_cancel;
  endsequence
  rst_pin_follow_a: assert property (debug_bus_reset_low == !debug_reset_request)
    else $error("debug bus reset does not mirror the reset request");
  cancel_single_a: assert property ($rose(transaction_cancel) |-> lone_pulse_s)
    else $error("cancel pulse longer than one cycle");
  // The update state lies well after the shift, so an early cancel means a decode slip.
  cancel_late_a: assert property (shift_end_s |-> !transaction_cancel[*6])
    else $error("cancel raised too soon after a shift");
  cancel_idle_a: assert property (transaction_cancel |-> tdo_oe_n)
    else $error("cancel raised while shifting");
  sel_quiet_a: assert property ($changed({access_port_index, access_port_bank})
    |-> tdo_oe_n)
    else $error("port select changed during a shift");
  req_quiet_a: assert property ($changed({debug_power_request, system_power_request,
    debug_reset_request}) |-> tdo_oe_n)
    else $error("request changed during a shift");
  tdo_low_phase_a: assert property ($changed(tdo) |-> !tck)
    else $error("data out moved while the test clock was high");
  oe_low_phase_a: assert property ($changed(tdo_oe_n) |-> !tck)
    else $error("output enable moved while the test clock was high");
endmodule
bind dp_debug_port dp_port_monitor #(.RESET_CTRL_EN(RESET_CTRL_EN)) mon (
  .core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
  .debug_power_request(debug_power_request), .system_power_request(system_power_request),
  .debug_reset_request(debug_reset_request), .debug_bus_reset_low(debug_bus_reset_low),
  .access_port_index(access_port_index), .access_port_bank(access_port_bank),
  .transaction_cancel(transaction_cancel)
);

// File: tb/dp_jtag_host.sv
// Behavioural debug host that clocks the scan chains.
`timescale 1ns/1ns
module dp_jtag_host (
  // Pins towards the debug port.
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // The test clock rests low between frames, as a real probe leaves it.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One period: pins set while low, answer taken late in the high phase.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #160 tck = 1'b1;
    #160 q = tdo;
    // Pins hold until the next step, so no pin is written twice in one time step.
    tck = 1'b0;
  endtask
  // Five ones reach reset from any state, then park in idle.
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // One scan from idle through the IR or DR path, LSB first, back to idle.
  task automatic scan(input bit ir, input int n, input logic [34:0] din,
    output logic [34:0] dout);
    logic q;
    #7;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the version-0 debug port.
`timescale 1ns/1ns
module tb_top;
  import dp_pkg::*;
  logic core_clk, arst_n, tck, tms, tdi, tdo, tdo_oe_n, tdo_pin;
  logic debug_power_acknowledge, system_power_acknowledge, debug_reset_acknowledge;
  logic error_event, compare_event, overrun_event, transaction_cancel;
  logic debug_power_request, system_power_request, debug_reset_request, debug_bus_reset_low;
  logic [7:0] access_port_index;
  logic [3:0] access_port_bank;
  logic [34:0] rsp;
  // Request pins packed for compact compares.
  logic [3:0] req_pins;
  int num_errors = 0;
  int cmp_count = 0;
  int cancel_count = 0;
  // The data pin is pulled high while the port does not drive it.
  assign tdo_pin = tdo_oe_n ? 1'b1 : tdo;
  assign req_pins = {debug_power_request, system_power_request, debug_reset_request,
    debug_bus_reset_low};
  dp_debug_port dut (.core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .debug_power_request(debug_power_request),
    .debug_power_acknowledge(debug_power_acknowledge),
    .system_power_request(system_power_request),
    .system_power_acknowledge(system_power_acknowledge),
    .debug_reset_request(debug_reset_request),
    .debug_reset_acknowledge(debug_reset_acknowledge),
    .debug_bus_reset_low(debug_bus_reset_low), .error_event(error_event),
    .compare_event(compare_event), .overrun_event(overrun_event),
    .access_port_index(access_port_index), .access_port_bank(access_port_bank),
    .transaction_cancel(transaction_cancel));
  dp_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));
  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Counts cancel pulses so the abort test can see exactly one; sampled mid-cycle when settled.
  always @(negedge core_clk) begin
    if (transaction_cancel === 1'b1) cancel_count++;
  end
  // Compares one value and reports a difference.
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask
  // One register access: instruction first, then the access chain.
  task automatic dp_acc(input logic rnw, input logic [3:0] addr, input logic [31:0] wd);
    host.scan(1'b1, 4, {31'h0, DP_IR_DPACC}, rsp);
    host.scan(1'b0, DP_LEN_ACC, {wd, addr[3:2], rnw}, rsp);
  endtask
  // A read lands in the buffer, so a second access fetches it.
  task automatic dp_read(input logic [3:0] addr, input logic [31:0] exp);
    dp_acc(1'b1, addr, 32'h0);
    dp_acc(1'b1, DP_ADDR_READ_BUFFER, 32'h0);
    check({29'h0, DP_ACK_OK}, {29'h0, rsp[2:0]});
    check(exp, rsp[34:3]);
  endtask
  // Raises the chosen events for one core cycle.
  task automatic pulse(input logic [2:0] ev);
    @(negedge core_clk) {error_event, compare_event, overrun_event} = ev;
    @(negedge core_clk) {error_event, compare_event, overrun_event} = 3'h0;
  endtask
  task automatic t_ident();
    logic [31:0] id_exp;
    id_exp = {DP_ID_VERSION, DP_ID_PART, DP_ID_DESIGNER, 1'b1};
    host.scan(1'b0, DP_LEN_ID, 35'h0, rsp);
    check(id_exp, rsp[31:0]);
    host.scan(1'b1, 4, {31'h0, DP_IR_TAP_IDENTIFICATION}, rsp);
    check(32'h1, {28'h0, rsp[3:0]});
    host.scan(1'b0, DP_LEN_ID, 35'h0, rsp);
    check(id_exp, rsp[31:0]);
    $display("test identification done");
  endtask
  task automatic t_control();
    dp_acc(1'b0, DP_ADDR_CONTROL_STATUS, 32'hffff_ffff);
    @(negedge core_clk) {debug_power_acknowledge, system_power_acknowledge} = 2'h3;
    debug_reset_acknowledge = 1'b1;
    dp_read(DP_ADDR_CONTROL_STATUS, 32'hfc00_0001);
    check(32'he, {28'h0, req_pins});
    dp_acc(1'b0, DP_ADDR_CONTROL_STATUS, 32'h0);
    @(negedge core_clk) {debug_power_acknowledge, system_power_acknowledge} = 2'h0;
    debug_reset_acknowledge = 1'b0;
    dp_read(DP_ADDR_CONTROL_STATUS, 32'h0);
    check(32'h1, {28'h0, req_pins});
    $display("test control done");
  endtask
  task automatic t_sticky();
    dp_acc(1'b0, DP_ADDR_CONTROL_STATUS, 32'h1);
    pulse(3'h7);
    dp_read(DP_ADDR_CONTROL_STATUS, 32'h33);
    dp_acc(1'b0, DP_ADDR_CONTROL_STATUS, 32'h21);
    dp_read(DP_ADDR_CONTROL_STATUS, 32'h13);
    dp_acc(1'b0, DP_ADDR_CONTROL_STATUS, 32'h12);
    pulse(3'h1);
    dp_read(DP_ADDR_CONTROL_STATUS, 32'h0);
    $display("test sticky flags done");
  endtask
  task automatic t_select();
    dp_acc(1'b0, DP_ADDR_PORT_SELECT, 32'hffff_ffff);
    dp_read(DP_ADDR_PORT_SELECT, 32'hff00_00f0);
    check(32'hfff, {20'h0, access_port_index, access_port_bank});
    dp_acc(1'b0, DP_ADDR_PORT_SELECT, 32'h5a00_0030);
    dp_acc(1'b0, DP_ADDR_RESERVED, 32'hffff_ffff);
    dp_read(DP_ADDR_RESERVED, 32'h0);
    dp_read(DP_ADDR_PORT_SELECT, 32'h5a00_0030);
    // A portable host confirms the select through its effect rather than a read-back.
    check(32'h5a3, {20'h0, access_port_index, access_port_bank});
    $display("test select done");
  endtask
  // Mid-run reset: every output falls back to its idle level and stays there after release.
  task automatic t_reset();
    @(negedge core_clk) arst_n = 1'b0;
    @(negedge core_clk) arst_n = 1'b1;
    // Two edges after release nothing may have moved yet.
    repeat (2) @(negedge core_clk);
    check(32'h0, {20'h0, access_port_index, access_port_bank});
    check(32'h1, {28'h0, req_pins});
    check(32'h2, {30'h0, tdo_oe_n, transaction_cancel});
    // The controller sits in its reset state again, so the host parks it in idle.
    host.tap_reset();
    $display("test reset done");
  endtask
  task automatic t_abort();
    host.scan(1'b1, 4, {31'h0, DP_IR_ABORT}, rsp);
    check(32'h0, cancel_count);
    host.scan(1'b0, DP_LEN_ACC, 35'h8, rsp);
    // Detection and the output register add three core cycles.
    repeat (4) @(negedge core_clk);
    check(32'h1, cancel_count);
    $display("test abort done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence.
  initial begin
    arst_n = 1'b0;
    {debug_power_acknowledge, system_power_acknowledge, debug_reset_acknowledge} = 3'h0;
    {error_event, compare_event, overrun_event} = 3'h0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1'b1;
    host.tap_reset();
    t_ident();
    t_control();
    t_sticky();
    t_select();
    t_reset();
    t_abort();
    stop_test();
  end
  // Watchdog, about twice the expected run.
  initial begin
    #1000000;
    num_errors++;
    stop_test();
  end
endmodule
